// *** hdl/tdc_pkg.sv ***
`default_nettype none
// ************************************************************
// constants of the demodulation capture timer
// ************************************************************
package tdc_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned PRE_W = 7;
   localparam int unsigned STS_W = 3;
   localparam int unsigned FILT_W = 8;
   localparam int unsigned FILT_BASE_BITS = 4;
   // register offsets
   localparam logic [7:0] OFS_CTL_A = 8'h00;
   localparam logic [7:0] OFS_CTL_B = 8'h01;
   localparam logic [7:0] OFS_CTL_C = 8'h02;
   localparam logic [7:0] OFS_CNT_HI = 8'h03;
   localparam logic [7:0] OFS_CNT_LO = 8'h04;
   localparam logic [7:0] OFS_RLD_HI = 8'h05;
   localparam logic [7:0] OFS_RLD_LO = 8'h06;
   localparam logic [7:0] OFS_CAPR_HI = 8'h07;
   localparam logic [7:0] OFS_CAPR_LO = 8'h08;
   localparam logic [7:0] OFS_CAPF_HI = 8'h09;
   localparam logic [7:0] OFS_CAPF_LO = 8'h0a;
   localparam logic [7:0] OFS_FILT = 8'h0b;
   localparam logic [7:0] OFS_PTR = 8'h0c;
   localparam logic [7:0] OFS_ALTF = 8'h0d;
   localparam logic [7:0] OFS_IEN_HI = 8'h0e;
   localparam logic [7:0] OFS_IEN_LO = 8'h0f;
   localparam logic [7:0] OFS_STS = 8'h10;
   localparam logic [7:0] OFS_MSK = 8'h11;
   // field positions
   localparam int unsigned CTLA_MODE_LSB = 4;
   localparam int unsigned CTLB_TEN = 7;
   localparam int unsigned CTLB_ICFG_LSB = 1;
   localparam int unsigned CTLC_CSC = 7;
   localparam int unsigned CTLC_EDGE_POLARITY_LOW = 6;
   localparam int unsigned CTLC_EDGE_POLARITY_HIGH = 4;
   localparam int unsigned CTLC_CLOCK_DIVIDER_SELECT_LSB = 1;
   localparam int unsigned CTLC_COUNT_CLOCK_SOURCE = 0;
   localparam int unsigned NFC_EN = 7;
   localparam int unsigned NFC_CTL_LSB = 4;
   localparam int unsigned IEN_TMR_BIT = 5;
   localparam int unsigned ALTF_IN = 0;
   localparam int unsigned ALTF_OUT = 1;
   localparam int unsigned STS_RISE = 0;
   localparam int unsigned STS_FALL = 1;
   localparam int unsigned STS_RLD = 2;
   // codes and reset values
   localparam logic [3:0] MODE_DEMOD = 4'hc;
   localparam logic [1:0] ICFG_CAPTURE = 2'h2;
   localparam logic [1:0] ICFG_RELOAD = 2'h3;
   localparam logic [1:0] POL_RISE = 2'h0;
   localparam logic [1:0] POL_FALL = 2'h1;
   localparam logic [7:0] SUBREG_ALTF = 8'h02;
   localparam logic [2:0] STS_CAP_MASK = 3'h3;
   localparam logic [2:0] STS_RLD_MASK = 3'h4;
   localparam logic [2:0] STS_ALL_MASK = 3'h7;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   typedef enum logic [1:0] {
      TDC_IDLE = 2'h0,
      TDC_WAIT = 2'h1,
      TDC_RUN = 2'h3
   } tdc_state_t;
endpackage : tdc_pkg
`default_nettype wire

// *** hdl/tdc_noise_filter.sv ***
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// up/down counting input noise filter
// ************************************************************
module tdc_noise_filter #(
   parameter int unsigned W = tdc_pkg::FILT_W
) (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic en_in,
   input wire logic [2:0] ctl_in,
   input wire logic din_in,
   output logic dout_out
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic out;
   } tdc_filt_t;

   tdc_filt_t r_ff;
   tdc_filt_t nxt_r;
   logic [W-1:0] top;
   int unsigned nb;

   // counter span grows with the control code, capped at the full width
   always_comb
   begin
      nb = int'(ctl_in) + tdc_pkg::FILT_BASE_BITS;
      if (nb > W)
      begin
         nb = W;
      end
      top = {W{1'b1}} >> (W - nb);
      nxt_r = r_ff;
      if (!en_in)
      begin
         // bypass keeps the count clear so enabling starts clean
         nxt_r.cnt = '0;
         nxt_r.out = din_in;
      end
      else if (din_in && r_ff.cnt < top)
      begin
         nxt_r.cnt = r_ff.cnt + 1'b1;
      end
      else if (!din_in && r_ff.cnt != '0)
      begin
         nxt_r.cnt = r_ff.cnt - 1'b1;
      end
      // output only flips at the rails, so short glitches die out
      if (en_in && r_ff.cnt >= top)
      begin
         nxt_r.out = 1'b1;
      end
      else if (en_in && r_ff.cnt == '0)
      begin
         nxt_r.out = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         r_ff <= '0;
      end
      else
      begin
         r_ff <= nxt_r;
      end
   end

   assign dout_out = r_ff.out;
endmodule : tdc_noise_filter
`default_nettype wire

// *** hdl/tdc_timer.sv ***
// Functional notes
// - demodulation runs only while the mode field holds 1100B
// - interrupt config 10B passes capture events only, not reload
// - polarity pair 10 triggers and captures on both edges
// - prescaler code 000B divides the count clock by one
// - count clock source one counts on the 32kHz peripheral clock
// - capture source zero takes events from the timer pin
// - filter enable bit; control 100B gives an 8-bit up/down filter
// - timer halts while run enable is zero; software sets it last
// - once enabled, wait for a trigger edge, then count each tick
// - rising edge copies count to rising capture, flags, keeps counting
// - falling edge copies count to falling capture, flags, keeps counting
// - at the reload value set reload flag and restore start value
// - reload value is high byte and low byte joined
// - start value comes from count high and low bytes
// - output delay and input capture select do nothing here
// - pointer value 02H selects the alternate function subregister
// - altfunc bit 0 routes pin to input, bit 1 output to pin
// - interrupt masked when both enable bits 5 are zero
`timescale 1ns/1ns
`default_nettype none
module tdc_timer (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic tin_pin_in,
   input wire logic alt_src_in,
   input wire logic periph_clk_in,
   output logic tout_out,
   output logic tout_oe_out,
   output logic irq_out
);
   typedef struct packed {
      logic [7:0] ctl_a;
      logic [7:0] ctl_b;
      logic [7:0] ctl_c;
      logic [7:0] nfc;
      logic [7:0] ptr;
      logic [7:0] altf;
      logic [7:0] ien_h;
      logic [7:0] ien_l;
      logic [15:0] start;
      logic [15:0] reload;
      logic [15:0] cap_r;
      logic [15:0] cap_f;
      logic [15:0] cnt;
      logic [2:0] sts;
      logic [2:0] msk;
      logic [6:0] pre;
      tdc_pkg::tdc_state_t st;
      logic tin_s1;
      logic tin_s2;
      logic alt_s1;
      logic alt_s2;
      logic ck_s1;
      logic ck_s2;
      logic ck_d;
      logic src_d;
      logic tout;
      logic [7:0] rdata;
   } tdc_regs_t;

   tdc_regs_t r_ff;
   tdc_regs_t nxt_r;
   logic filt_out;
   logic src;
   logic ev_rise;
   logic ev_fall;
   logic rise_en;
   logic fall_en;
   logic trig;
   logic src_tick;
   logic cnt_en;
   logic demod;
   logic timer_run_enable;
   logic [1:0] pol;
   logic [2:0] clock_divider_select;
   logic [6:0] pmask;
   logic [2:0] sts_set;
   logic [2:0] sts_clr;
   logic [2:0] icfg_mask;
   logic irq_gate;

   // ************************************************************
   // input path
   // ************************************************************

   tdc_noise_filter #(
      .W(tdc_pkg::FILT_W)
   ) u_filt (
      .clk_sys_in(clk_sys_in),
      .nrst_in(nrst_in),
      .en_in(r_ff.nfc[tdc_pkg::NFC_EN]),
      .ctl_in(r_ff.nfc[tdc_pkg::NFC_CTL_LSB +: 3]),
      .din_in(r_ff.tin_s2),
      .dout_out(filt_out)
   );

   // control fields decoded once
   always_comb
   begin
      timer_run_enable = r_ff.ctl_b[tdc_pkg::CTLB_TEN];
      demod = (r_ff.ctl_a[tdc_pkg::CTLA_MODE_LSB +: 4] == tdc_pkg::MODE_DEMOD);
      pol = {r_ff.ctl_c[tdc_pkg::CTLC_EDGE_POLARITY_HIGH], r_ff.ctl_c[tdc_pkg::CTLC_EDGE_POLARITY_LOW]};
      clock_divider_select = r_ff.ctl_c[tdc_pkg::CTLC_CLOCK_DIVIDER_SELECT_LSB +: 3];
   end

   // event source and edge detection; a pin not routed reads as low
   always_comb
   begin
      if (r_ff.ctl_c[tdc_pkg::CTLC_CSC])
      begin
         src = r_ff.alt_s2;
      end
      else
      begin
         src = filt_out & r_ff.altf[tdc_pkg::ALTF_IN];
      end
      ev_rise = src & ~r_ff.src_d;
      ev_fall = ~src & r_ff.src_d;
      rise_en = (pol != tdc_pkg::POL_FALL);
      fall_en = (pol != tdc_pkg::POL_RISE);
      trig = (ev_rise & rise_en) | (ev_fall & fall_en);
   end

   // ************************************************************
   // count clock and prescaler
   // ************************************************************

   always_comb
   begin
      if (r_ff.ctl_c[tdc_pkg::CTLC_COUNT_CLOCK_SOURCE])
      begin
         src_tick = r_ff.ck_s2 & ~r_ff.ck_d;
      end
      else
      begin
         src_tick = 1'b1;
      end
      pmask = 7'((8'h01 << clock_divider_select) - 8'h01);
      cnt_en = src_tick && (r_ff.pre == pmask);
   end

   // ************************************************************
   // interrupt
   // ************************************************************

   // sticky flags stay visible even when config keeps them off the line
   always_comb
   begin
      case (r_ff.ctl_b[tdc_pkg::CTLB_ICFG_LSB +: 2])
         tdc_pkg::ICFG_CAPTURE: icfg_mask = tdc_pkg::STS_CAP_MASK;
         tdc_pkg::ICFG_RELOAD: icfg_mask = tdc_pkg::STS_RLD_MASK;
         default: icfg_mask = tdc_pkg::STS_ALL_MASK;
      endcase
      irq_gate = r_ff.ien_h[tdc_pkg::IEN_TMR_BIT] | r_ff.ien_l[tdc_pkg::IEN_TMR_BIT];
   end

   assign irq_out = irq_gate && ((r_ff.sts & r_ff.msk & icfg_mask) != '0);

   // ************************************************************
   // main next state
   // ************************************************************

   always_comb
   begin
      nxt_r = r_ff;
      sts_set = '0;
      sts_clr = '0;
      // synchronisers: first stage feeds only the second
      nxt_r.tin_s1 = tin_pin_in;
      nxt_r.tin_s2 = r_ff.tin_s1;
      nxt_r.alt_s1 = alt_src_in;
      nxt_r.alt_s2 = r_ff.alt_s1;
      nxt_r.ck_s1 = periph_clk_in;
      nxt_r.ck_s2 = r_ff.ck_s1;
      nxt_r.ck_d = r_ff.ck_s2;
      nxt_r.src_d = src;
      nxt_r.rdata = tdc_pkg::RST_BYTE;

      // register writes; delay and capture select bits are stored but unused
      if (wr_in)
      begin
         case (addr_in)
            tdc_pkg::OFS_CTL_A: nxt_r.ctl_a = wdata_in;
            tdc_pkg::OFS_CTL_B: nxt_r.ctl_b = wdata_in;
            tdc_pkg::OFS_CTL_C: nxt_r.ctl_c = wdata_in;
            tdc_pkg::OFS_CNT_HI:
            begin
               if (!timer_run_enable)
               begin
                  nxt_r.start[15:8] = wdata_in;
                  nxt_r.cnt[15:8] = wdata_in;
               end
            end
            tdc_pkg::OFS_CNT_LO:
            begin
               if (!timer_run_enable)
               begin
                  nxt_r.start[7:0] = wdata_in;
                  nxt_r.cnt[7:0] = wdata_in;
               end
            end
            tdc_pkg::OFS_RLD_HI: nxt_r.reload[15:8] = wdata_in;
            tdc_pkg::OFS_RLD_LO: nxt_r.reload[7:0] = wdata_in;
            tdc_pkg::OFS_CAPR_HI: nxt_r.cap_r[15:8] = wdata_in;
            tdc_pkg::OFS_CAPR_LO: nxt_r.cap_r[7:0] = wdata_in;
            tdc_pkg::OFS_CAPF_HI: nxt_r.cap_f[15:8] = wdata_in;
            tdc_pkg::OFS_CAPF_LO: nxt_r.cap_f[7:0] = wdata_in;
            tdc_pkg::OFS_FILT: nxt_r.nfc = wdata_in;
            tdc_pkg::OFS_PTR: nxt_r.ptr = wdata_in;
            tdc_pkg::OFS_ALTF:
            begin
               if (r_ff.ptr == tdc_pkg::SUBREG_ALTF)
               begin
                  nxt_r.altf = wdata_in;
               end
            end
            tdc_pkg::OFS_IEN_HI: nxt_r.ien_h = wdata_in;
            tdc_pkg::OFS_IEN_LO: nxt_r.ien_l = wdata_in;
            tdc_pkg::OFS_STS: sts_clr = wdata_in[2:0];
            tdc_pkg::OFS_MSK: nxt_r.msk = wdata_in[2:0];
            default: nxt_r.rdata = tdc_pkg::RST_BYTE;
         endcase
      end

      // register reads, answered in the next cycle only
      if (rd_in)
      begin
         case (addr_in)
            tdc_pkg::OFS_CTL_A: nxt_r.rdata = r_ff.ctl_a;
            tdc_pkg::OFS_CTL_B: nxt_r.rdata = r_ff.ctl_b;
            tdc_pkg::OFS_CTL_C: nxt_r.rdata = r_ff.ctl_c;
            tdc_pkg::OFS_CNT_HI: nxt_r.rdata = r_ff.cnt[15:8];
            tdc_pkg::OFS_CNT_LO: nxt_r.rdata = r_ff.cnt[7:0];
            tdc_pkg::OFS_RLD_HI: nxt_r.rdata = r_ff.reload[15:8];
            tdc_pkg::OFS_RLD_LO: nxt_r.rdata = r_ff.reload[7:0];
            tdc_pkg::OFS_CAPR_HI: nxt_r.rdata = r_ff.cap_r[15:8];
            tdc_pkg::OFS_CAPR_LO: nxt_r.rdata = r_ff.cap_r[7:0];
            tdc_pkg::OFS_CAPF_HI: nxt_r.rdata = r_ff.cap_f[15:8];
            tdc_pkg::OFS_CAPF_LO: nxt_r.rdata = r_ff.cap_f[7:0];
            tdc_pkg::OFS_FILT: nxt_r.rdata = r_ff.nfc;
            tdc_pkg::OFS_PTR: nxt_r.rdata = r_ff.ptr;
            tdc_pkg::OFS_ALTF:
            begin
               if (r_ff.ptr == tdc_pkg::SUBREG_ALTF)
               begin
                  nxt_r.rdata = r_ff.altf;
               end
            end
            tdc_pkg::OFS_IEN_HI: nxt_r.rdata = r_ff.ien_h;
            tdc_pkg::OFS_IEN_LO: nxt_r.rdata = r_ff.ien_l;
            tdc_pkg::OFS_STS: nxt_r.rdata = {5'h00, r_ff.sts};
            tdc_pkg::OFS_MSK: nxt_r.rdata = {5'h00, r_ff.msk};
            default: nxt_r.rdata = tdc_pkg::RST_BYTE;
         endcase
      end

      // prescaler only runs while counting so every start is aligned
      if (r_ff.st != tdc_pkg::TDC_RUN)
      begin
         nxt_r.pre = '0;
      end
      else if (src_tick)
      begin
         nxt_r.pre = cnt_en ? '0 : r_ff.pre + 1'b1;
      end

      // timer sequence
      case (r_ff.st)
         tdc_pkg::TDC_IDLE:
         begin
            if (timer_run_enable && demod)
            begin
               nxt_r.st = tdc_pkg::TDC_WAIT;
               nxt_r.cnt = r_ff.start;
            end
         end
         tdc_pkg::TDC_WAIT:
         begin
            if (trig)
            begin
               nxt_r.st = tdc_pkg::TDC_RUN;
            end
         end
         tdc_pkg::TDC_RUN:
         begin
            if (cnt_en && r_ff.cnt == r_ff.reload)
            begin
               nxt_r.cnt = r_ff.start;
               nxt_r.tout = ~r_ff.tout;
               sts_set[tdc_pkg::STS_RLD] = 1'b1;
            end
            else if (cnt_en)
            begin
               nxt_r.cnt = r_ff.cnt + 1'b1;
            end
            if (ev_rise && rise_en)
            begin
               nxt_r.cap_r = r_ff.cnt;
               sts_set[tdc_pkg::STS_RISE] = 1'b1;
            end
            if (ev_fall && fall_en)
            begin
               nxt_r.cap_f = r_ff.cnt;
               sts_set[tdc_pkg::STS_FALL] = 1'b1;
            end
         end
         default: nxt_r.st = tdc_pkg::TDC_IDLE;
      endcase

      if (!timer_run_enable || !demod)
      begin
         nxt_r.st = tdc_pkg::TDC_IDLE;
      end

      // a new event beats a clear written in the same cycle
      nxt_r.sts = (r_ff.sts & ~sts_clr) | sts_set;
   end

   // state register
   always_ff @(posedge clk_sys_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         r_ff <= '0;
      end
      else
      begin
         r_ff <= nxt_r;
      end
   end

   assign rdata_out = r_ff.rdata;
   assign tout_out = r_ff.tout;
   assign tout_oe_out = r_ff.altf[tdc_pkg::ALTF_OUT];

   // ************************************************************
   // checks
   // ************************************************************

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!nrst_in);

   sequence s_rise_cap;
      r_ff.st == tdc_pkg::TDC_RUN && ev_rise && rise_en && !wr_in;
   endsequence
   sequence s_fall_cap;
      r_ff.st == tdc_pkg::TDC_RUN && ev_fall && fall_en && !wr_in;
   endsequence
   sequence s_wrap;
      r_ff.st == tdc_pkg::TDC_RUN && cnt_en && r_ff.cnt == r_ff.reload && timer_run_enable;
   endsequence

   a_mode_gate: assert property (
      r_ff.st != tdc_pkg::TDC_IDLE |-> $past(demod))
      else $error("timer active outside demodulation mode");
   a_irq_cap_only: assert property (
      irq_out && r_ff.ctl_b[tdc_pkg::CTLB_ICFG_LSB +: 2] == tdc_pkg::ICFG_CAPTURE
      |-> (r_ff.sts & r_ff.msk & tdc_pkg::STS_CAP_MASK) != '0)
      else $error("interrupt raised by a reload in capture only config");
   a_both_edges: assert property (
      pol == 2'h2 && ev_fall |-> fall_en && rise_en)
      else $error("both edge polarity not decoded");
   a_div_one: assert property (
      r_ff.st == tdc_pkg::TDC_RUN && clock_divider_select == 3'h0
      && !r_ff.ctl_c[tdc_pkg::CTLC_COUNT_CLOCK_SOURCE] |-> cnt_en)
      else $error("undivided clock missed a tick");
   a_halt_idle: assert property (
      !timer_run_enable |=> r_ff.st == tdc_pkg::TDC_IDLE)
      else $error("timer kept running with enable low");
   a_wait_trig: assert property (
      r_ff.st == tdc_pkg::TDC_WAIT ##1 r_ff.st == tdc_pkg::TDC_RUN |-> $past(trig))
      else $error("counting began without a trigger edge");
   a_rise_cap: assert property (
      s_rise_cap |=> r_ff.cap_r == $past(r_ff.cnt) && r_ff.sts[tdc_pkg::STS_RISE])
      else $error("rising capture lost");
   a_fall_cap: assert property (
      s_fall_cap |=> r_ff.cap_f == $past(r_ff.cnt) && r_ff.sts[tdc_pkg::STS_FALL])
      else $error("falling capture lost");
   a_reload_wrap: assert property (
      s_wrap and demod |=> r_ff.cnt == r_ff.start && r_ff.sts[tdc_pkg::STS_RLD])
      else $error("reload did not restore start value");
   a_irq_masked: assert property (
      !r_ff.ien_h[tdc_pkg::IEN_TMR_BIT] && !r_ff.ien_l[tdc_pkg::IEN_TMR_BIT] |-> !irq_out)
      else $error("interrupt with both enables low");
   a_cap_hold: assert property (
      !(ev_rise && rise_en) && !wr_in |=> $stable(r_ff.cap_r))
      else $error("rising capture changed without an event");
   a_fall_hold: assert property (
      !(ev_fall && fall_en) && !wr_in |=> $stable(r_ff.cap_f))
      else $error("falling capture changed without an event");
endmodule : tdc_timer
`default_nettype wire

// *** verif/tdc_sig_src.sv ***
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// far-side source of the modulated timer input
// ************************************************************
module tdc_sig_src #(
   parameter int unsigned MIN_HOLD = 2,
   parameter int unsigned HALF = 8
) (
   input wire logic clk_sys_in,
   input wire logic lvl_req_in,
   output logic tin_out,
   output logic per_clk_out
);
   int unsigned held = 0;
   int unsigned ph = 0;
   initial tin_out = 1'b0;
   initial per_clk_out = 1'b0;
   // the pin moves only after standing a while, so the synchroniser never misses an edge
   always @(posedge clk_sys_in)
   begin
      held <= held + 1;
      if (lvl_req_in != tin_out && held >= MIN_HOLD)
      begin
         tin_out <= lvl_req_in;
         held <= 0;
      end
   end
   // slow peripheral tick, scaled far below 32kHz ratio to keep the run short
   always @(posedge clk_sys_in)
   begin
      ph <= (ph == HALF - 1) ? 0 : ph + 1;
      if (ph == HALF - 1)
         per_clk_out <= ~per_clk_out;
   end
endmodule : tdc_sig_src
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin mismatches++; \
   $display("FAIL %s expected %h seen %h", nm, e, s); end end
module tb_top;
   logic clk_sys_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic lvl = 1'b0;
   logic [7:0] rdata_out;
   logic tin, per_clk, tout_out, tout_oe_out, irq_out;
   int mismatches = 0;
   int checked = 0;
   int cycles = 0;
   logic [7:0] d;
   logic [15:0] v;
   // offset, write value, value read back
   logic [23:0] rows [13] = '{24'h00c0c0, 24'h010404, 24'h021010, 24'h05abab, 24'h06cdcd,
      24'h0bc0c0, 24'h0c0202, 24'h0d0303, 24'h0e2020, 24'h0f2020, 24'h110707, 24'h20ff00,
      24'h12ff00};
   tdc_timer dut_u (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .tin_pin_in(tin), .alt_src_in(lvl), .periph_clk_in(per_clk), .tout_out(tout_out),
      .tout_oe_out(tout_oe_out), .irq_out(irq_out));
   tdc_sig_src src_u (.clk_sys_in(clk_sys_in), .lvl_req_in(lvl), .tin_out(tin),
      .per_clk_out(per_clk));
   always #2 clk_sys_in = ~clk_sys_in;
   // ************************************************************
   // bus tasks and verdict
   // ************************************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] w);
      @(posedge clk_sys_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= w;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      @(posedge clk_sys_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      #1 r = rdata_out;
   endtask : rd
   task automatic rd16(input logic [7:0] a, output logic [15:0] w);
      rd(a, w[15:8]);
      rd(a + 8'h01, w[7:0]);
   endtask : rd16
   task automatic pin(input logic l, input int n);
      @(posedge clk_sys_in);
      lvl <= l;
      repeat (n) @(posedge clk_sys_in);
   endtask : pin
   task automatic complete_run;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run
   // hang guard, well above the roughly 1150 cycles the tests need
   always @(posedge clk_sys_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         complete_run();
      end
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      repeat (2) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      `CHK("irq_rst", 1'b0, irq_out)
      for (int i = 0; i <= 17; i++)
      begin
         rd(i[7:0], d);
         `CHK("reset_val", 8'h00, d)
      end
      for (int i = 0; i < 13; i++)
      begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], d);
         `CHK("reg_rw", rows[i][7:0], d)
      end
      `CHK("tout_oe", 1'b1, tout_oe_out)
      wr(8'h0c, 8'h01);
      rd(8'h0d, d);
      `CHK("altf_hidden", 8'h00, d)
      wr(8'h0c, 8'h02);
      // start 0001, reload 0100; enable written last
      wr(8'h05, 8'h01);
      wr(8'h06, 8'h00);
      wr(8'h03, 8'h00);
      wr(8'h04, 8'h01);
      wr(8'h01, 8'h84);
      pin(1'b1, 10);
      pin(1'b0, 20);
      rd16(8'h03, v);
      `CHK("filter_glitch", 16'h0001, v)
      pin(1'b1, 400);
      rd16(8'h03, v);
      `CHK("trig_count", 1'b1, v > 16'h0001)
      wr(8'h01, 8'h04);
      wr(8'h0b, 8'h00);
      wr(8'h10, 8'h07);
      wr(8'h01, 8'h84);
      pin(1'b0, 40);
      pin(1'b1, 20);
      rd16(8'h07, v);
      `CHK("cap_rise", 1'b1, v >= 16'h0024 && v <= 16'h002c)
      rd16(8'h09, v);
      `CHK("fall_empty", 16'h0000, v)
      rd(8'h10, d);
      `CHK("sts_rise", 8'h01, d)
      `CHK("irq_cap", 1'b1, irq_out)
      pin(1'b0, 10);
      rd16(8'h09, v);
      `CHK("cap_fall", 1'b1, v >= 16'h0044 && v <= 16'h004c)
      rd16(8'h07, v);
      `CHK("rise_hold", 1'b1, v >= 16'h0024 && v <= 16'h002c)
      repeat (300) @(posedge clk_sys_in);
      // exactly one wrap so far, so the output has toggled once
      `CHK("tout_wrap", 1'b1, tout_out)
      rd(8'h10, d);
      `CHK("sts_reload", 8'h07, d)
      wr(8'h10, 8'h03);
      rd(8'h10, d);
      `CHK("sts_w1c", 8'h04, d)
      `CHK("irq_no_rld", 1'b0, irq_out)
      wr(8'h01, 8'h86);
      @(posedge clk_sys_in);
      `CHK("irq_rld", 1'b1, irq_out)
      wr(8'h0e, 8'h00);
      @(posedge clk_sys_in);
      `CHK("irq_one_en", 1'b1, irq_out)
      wr(8'h0f, 8'h00);
      @(posedge clk_sys_in);
      `CHK("irq_masked", 1'b0, irq_out)
      // halted timer ignores edges
      wr(8'h01, 8'h04);
      wr(8'h10, 8'h07);
      pin(1'b1, 10);
      pin(1'b0, 10);
      rd(8'h10, d);
      `CHK("halted", 8'h00, d)
      // slow count clock source
      wr(8'h02, 8'h11);
      wr(8'h01, 8'h84);
      pin(1'b1, 64);
      rd16(8'h03, v);
      `CHK("slow_clk", 1'b1, v >= 16'h0002 && v <= 16'h0008)
      // other mode: no demodulation
      wr(8'h01, 8'h04);
      wr(8'h00, 8'h00);
      wr(8'h10, 8'h07);
      wr(8'h01, 8'h84);
      pin(1'b0, 10);
      pin(1'b1, 10);
      pin(1'b0, 10);
      rd(8'h10, d);
      `CHK("no_demod", 8'h00, d)
      // alternate source with the pin unrouted, rising edges only
      wr(8'h01, 8'h04);
      wr(8'h0d, 8'h02);
      wr(8'h00, 8'hc0);
      wr(8'h02, 8'h80);
      wr(8'h10, 8'h07);
      wr(8'h01, 8'h84);
      pin(1'b1, 10);
      pin(1'b0, 10);
      pin(1'b1, 10);
      rd(8'h10, d);
      `CHK("alt_rise_only", 8'h01, d)
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
